// ### verilog/two_wire_pkg.sv
// constants shared by the addressed two-wire serial bus block
// assumes a single 125 MHz clock and a 32-bit wishbone register bus
package two_wire_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int ACK_TIMEOUT_US = 64;
    localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
    localparam logic [3:0] HALF_DIV16 = 4'h8; // clk cycles per half sck
    localparam logic [3:0] HALF_DIV8  = 4'h4;
    localparam logic [3:0] LAST_BIT   = 4'h7;

    // ------------------------------------------------------------
    // register byte offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_OFS     = 8'h00;
    localparam logic [7:0] BIC_OFS      = 8'h04;
    localparam logic [7:0] SHIFT_OFS    = 8'h08;
    localparam logic [7:0] OWN_ADDR_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS   = 8'h10;
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] BIC_RST      = 8'h00;
    localparam logic [7:0] SHIFT_RST    = 8'hFF;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_EN_BIT  = 7;  // serial_enable_bit
    localparam int MODE_COI_BIT = 6;  // address_match_status
    localparam int MODE_WUP_BIT = 5;  // wake_up_select
    localparam int MODE_PIN_BIT = 4;  // mode_field_bit4
    localparam logic [1:0] MODE_FIELD_SBI = 2'h2; // bits 3:2
    localparam int BIC_RELEASE_TRIGGER_BIT = 7;
    localparam int BIC_COMMAND_TRIGGER_BIT = 6;
    localparam int BIC_RELD_BIT = 5;
    localparam int BIC_CMDD_BIT = 4;
    localparam int BIC_ACKE_BIT = 2;
    localparam int BIC_ACK_DETECTED_FLAG_BIT = 1;
    localparam int BIC_BUSY_BIT = 0;
    localparam int ST_IRQ_BIT   = 0;
    localparam int ST_TOUT_BIT  = 1;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_EXT   = 2'h0,
        CLK_TMR   = 2'h1,
        CLK_DIV16 = 2'h2,
        CLK_DIV8  = 2'h3
    } clk_sel_t;

    typedef enum logic [1:0] {
        CLS_DATA = 2'h0,
        CLS_CMD  = 2'h1,
        CLS_ADDR = 2'h2
    } byte_class_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SHIFT = 2'h1,
        ST_ACK   = 2'h3,
        ST_BUSY  = 2'h2
    } xfer_state_t;

endpackage

// ### verilog/serial_clock_gen.sv
// half-period tick source for the internally made serial clock
// assumes one clock; the timer output arrives synchronous to it
`timescale 1ns/1ps
module serial_clock_gen
    import two_wire_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       timer_output_i,
    output logic            tick_o
);
    logic [3:0] cnt_q;
    logic       tmr_prev_q;
    logic [3:0] half_lim;

    // ------------------------------------------------------------
    // divider and timer edge
    // ------------------------------------------------------------
    assign half_lim = (sel_i == CLK_DIV16) ? HALF_DIV16 : HALF_DIV8;

    // counter restarts whenever the clock is parked
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == half_lim - 4'h1) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_prev_q <= 1'b0;
        end else begin
            tmr_prev_q <= timer_output_i;
        end
    end

    // one pulse per half period of the chosen source
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            tick_o <= 1'b0;
        end else if (sel_i == CLK_TMR) begin
            tick_o <= timer_output_i && !tmr_prev_q;
        end else begin
            tick_o <= (sel_i != CLK_EXT) && (cnt_q == half_lim - 4'h1);
        end
    end
endmodule // serial_clock_gen

// ### verilog/two_wire_bus.sv
// addressed two-wire serial bus port, slave or master, with registers
// assumes classic wishbone master, pins synchronous to clk_i
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module two_wire_bus
    import two_wire_pkg::*;
#(
    parameter int ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        timer_output_i,
    input  wire logic        first_data_line_i,
    output logic             first_data_line_o,
    output logic             first_data_line_oe_o,
    input  wire logic        second_data_line_i,
    output logic             second_data_line_o,
    output logic             second_data_line_oe_o
);
    logic [7:0]  mode_q, bic_q, shift_q, own_addr_q;
    logic        rel_det_q, cmd_det_q, rel_new_q, cmd_new_q;
    logic        ack_detected_flag_q, irq_q, tout_q, selected_q;
    logic        out_latch_q, ack_drv_q, busy_drv_q, ack_half_q;
    logic        sck_prev_q, sda_prev_q;
    logic [1:0]  cls_q;
    logic [3:0]  bit_cnt_q;
    logic [13:0] tout_cnt_q;
    xfer_state_t state_q;
    logic        en, wake_up_select, internal, sck_now, sda_in, sck_rise, sck_fall;
    logic        idle_hi, wr, rd_req, wr_mode, wr_bic, wr_shift, start;
    logic        complete, is_addr, match, tick, drive_low;
    logic [7:0]  rx_byte, rd_mux;

    // ------------------------------------------------------------
    // pin and edge view
    // ------------------------------------------------------------
    assign en       = mode_q[MODE_EN_BIT] &&
                      mode_q[3:2] == MODE_FIELD_SBI;
    assign wake_up_select      = mode_q[MODE_WUP_BIT];
    assign internal = mode_q[1:0] != CLK_EXT;
    assign sck_now  = internal ? sck_o : sck_i;
    assign sda_in   = mode_q[MODE_PIN_BIT] ? second_data_line_i
                                           : first_data_line_i;
    assign sck_rise = en && sck_now && !sck_prev_q;
    assign sck_fall = en && !sck_now && sck_prev_q;
    assign idle_hi  = en && state_q == ST_IDLE && sck_now && sck_prev_q;
    assign rx_byte  = {shift_q[6:0], sda_in};
    assign complete = state_q == ST_SHIFT && sck_rise &&
                      bit_cnt_q == LAST_BIT;
    assign is_addr  = rel_new_q && cmd_new_q;
    assign match    = rx_byte == own_addr_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_now;
            sda_prev_q <= sda_in;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, write at ack
    // ------------------------------------------------------------
    assign rd_req   = cyc_i && stb_i && !ack_o;
    assign wr       = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign wr_mode  = wr && adr_i == MODE_OFS;
    assign wr_bic   = wr && adr_i == BIC_OFS;
    assign wr_shift = wr && adr_i == SHIFT_OFS;
    // a new byte may only go out when the link is idle and clock high
    assign start    = wr_shift && idle_hi;

    always_comb begin
        rd_mux = 8'h00;
        unique case (adr_i)
            MODE_OFS: begin
                rd_mux = mode_q;
                rd_mux[MODE_COI_BIT] = shift_q == own_addr_q;
            end
            BIC_OFS: begin
                rd_mux = bic_q;
                rd_mux[BIC_RELD_BIT] = rel_det_q;
                rd_mux[BIC_CMDD_BIT] = cmd_det_q;
                rd_mux[BIC_ACK_DETECTED_FLAG_BIT] = ack_detected_flag_q;
            end
            SHIFT_OFS:    rd_mux = shift_q;
            OWN_ADDR_OFS: rd_mux = own_addr_q;
            STATUS_OFS:   rd_mux = {2'h0, selected_q, cls_q,
                                    busy_drv_q, tout_q, irq_q};
            default:      rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= rd_req;
            if (rd_req) begin
                dat_o <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // match bit is computed, never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RST;
        end else if (wr_mode) begin
            mode_q <= dat_i[7:0] & ~(8'h01 << MODE_COI_BIT);
        end
    end

    // trigger and detect bits are not kept here; they self clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bic_q <= BIC_RST;
        end else if (wr_bic) begin
            bic_q <= dat_i[7:0] & 8'h05;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_addr_q <= OWN_ADDR_RST;
        end else if (wr && adr_i == OWN_ADDR_OFS) begin
            own_addr_q <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // bus condition detection and byte classing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            rel_det_q <= 1'b0;
            cmd_det_q <= 1'b0;
            rel_new_q <= 1'b0;
            cmd_new_q <= 1'b0;
        end else if (idle_hi && sda_in && !sda_prev_q) begin
            rel_det_q <= 1'b1;
            rel_new_q <= 1'b1;
            cmd_det_q <= 1'b0;
            cmd_new_q <= 1'b0;
        end else if (idle_hi && !sda_in && sda_prev_q) begin
            cmd_det_q <= 1'b1;
            cmd_new_q <= 1'b1;
        end else if (complete) begin
            cmd_new_q <= 1'b0;
            rel_new_q <= 1'b0;
            if (is_addr && !match) begin
                rel_det_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cls_q      <= CLS_DATA;
            selected_q <= 1'b0;
        end else if (complete) begin
            if (is_addr) begin
                cls_q      <= CLS_ADDR;
                selected_q <= match;
            end else begin
                cls_q <= cmd_new_q ? CLS_CMD : CLS_DATA;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= 4'h0;
            ack_half_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q   <= ST_SHIFT;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_SHIFT: begin
                    if (sck_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (complete) begin
                            state_q <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (sck_fall) begin
                        ack_half_q <= !ack_half_q;
                        if (ack_half_q) begin
                            state_q <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY: begin
                    // leave once no one holds the line low
                    if (sck_rise && sda_in && !busy_drv_q) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // shifter samples on the rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= SHIFT_RST;
        end else if (wr_shift && state_q == ST_IDLE) begin
            shift_q <= dat_i[7:0];
        end else if (state_q == ST_SHIFT && sck_rise) begin
            shift_q <= rx_byte;
        end
    end

    // output latch: msb at start, next bit on each fall after a rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_latch_q <= 1'b1;
        end else if (start) begin
            out_latch_q <= dat_i[7];
        end else if (state_q == ST_SHIFT && sck_fall &&
                     bit_cnt_q != 4'h0) begin
            out_latch_q <= shift_q[7];
        end else if (complete) begin
            out_latch_q <= 1'b1;
        end else if (wr_bic && dat_i[BIC_COMMAND_TRIGGER_BIT]) begin
            out_latch_q <= 1'b0;
        end else if (wr_bic && dat_i[BIC_RELEASE_TRIGGER_BIT]) begin
            out_latch_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // acknowledge, busy and flags
    // ------------------------------------------------------------
    // ack spans the ninth clock, busy follows on the same fall
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            ack_drv_q  <= 1'b0;
            busy_drv_q <= 1'b0;
        end else if (sck_fall) begin
            if (state_q == ST_ACK && !ack_half_q) begin
                ack_drv_q <= bic_q[BIC_ACKE_BIT];
            end else if (state_q == ST_ACK) begin
                ack_drv_q  <= 1'b0;
                busy_drv_q <= bic_q[BIC_BUSY_BIT];
            end else if (!bic_q[BIC_BUSY_BIT] && !wake_up_select) begin
                busy_drv_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || start) begin
            ack_detected_flag_q <= 1'b0;
        end else if (sck_fall && state_q == ST_ACK && ack_half_q &&
                     !sda_in) begin
            ack_detected_flag_q <= 1'b1;
        end
    end

    // no acknowledge within the window marks the byte as lost
    always_ff @(posedge clk_i) begin
        // keeps counting once the link parks, so silence is still caught
        if (rst_i || state_q == ST_SHIFT || ack_detected_flag_q) begin
            tout_cnt_q <= 14'h0000;
        end else if ((state_q != ST_IDLE || tout_cnt_q != 14'h0000) &&
                     tout_cnt_q != ACK_TIMEOUT_CYCLES[13:0]) begin
            tout_cnt_q <= tout_cnt_q + 14'h0001;
        end
    end

    // hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q  <= 1'b0;
            tout_q <= 1'b0;
        end else begin
            if (complete && (!wake_up_select || (is_addr && match))) begin
                irq_q <= 1'b1;
            end else if (wr && adr_i == STATUS_OFS &&
                         dat_i[ST_IRQ_BIT]) begin
                irq_q <= 1'b0;
            end
            if (!ack_detected_flag_q &&
                tout_cnt_q == ACK_TIMEOUT_CYCLES[13:0] - 14'h0001) begin
                tout_q <= 1'b1;
            end else if (wr && adr_i == STATUS_OFS &&
                         dat_i[ST_TOUT_BIT]) begin
                tout_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers: enables and sck registered, data levels tied low
    // ------------------------------------------------------------
    // wake-up keeps the data pin off except for a pending busy
    assign drive_low = en && (((!out_latch_q || ack_drv_q) && !wake_up_select) ||
                              busy_drv_q);
    assign first_data_line_o  = 1'b0;
    assign second_data_line_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_data_line_oe_o  <= 1'b0;
            second_data_line_oe_o <= 1'b0;
            sck_oe_o              <= 1'b0;
        end else begin
            first_data_line_oe_o  <= drive_low && !mode_q[MODE_PIN_BIT];
            second_data_line_oe_o <= drive_low && mode_q[MODE_PIN_BIT];
            sck_oe_o              <= en && internal;
        end
    end

    // internal clock parks high; only runs while a byte is active
    always_ff @(posedge clk_i) begin
        if (rst_i || !internal || !en) begin
            sck_o <= 1'b1;
        end else if (tick) begin
            sck_o <= !sck_o;
        end
    end

    serial_clock_gen u_clk_gen (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .run_i          (en && internal && state_q != ST_IDLE),
        .sel_i          (mode_q[1:0]),
        .timer_output_i (timer_output_i),
        .tick_o         (tick)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_rel_detect: assert property (idle_hi && sda_in && !sda_prev_q
        |=> rel_det_q) else $error("release not caught");
    a_cmd_detect: assert property (idle_hi && !sda_in && sda_prev_q
        |=> cmd_det_q) else $error("command not caught");
    a_addr_select: assert property (complete && is_addr && match
        |=> selected_q && cls_q == CLS_ADDR)
        else $error("address match lost");
    a_cmd_class: assert property (complete && cmd_new_q && !rel_new_q
        |=> cls_q == CLS_CMD) else $error("command misclassed");
    a_ack_source: assert property ($rose(ack_drv_q)
        |-> $past(state_q) == ST_ACK && $past(sck_fall))
        else $error("ack outside ninth clock");
    a_busy_follow: assert property ($fell(ack_drv_q) && $past(en)
        |-> busy_drv_q == $past(bic_q[BIC_BUSY_BIT]))
        else $error("busy not after ack");
    a_busy_stop: assert property (busy_drv_q && sck_fall && !wake_up_select &&
        !bic_q[BIC_BUSY_BIT] && state_q != ST_ACK |=> !busy_drv_q)
        else $error("busy held after clear");
    a_irq_every: assert property (complete && !wake_up_select |=> irq_q)
        else $error("transfer flag missed");
    a_wake_quiet: assert property (wake_up_select && !busy_drv_q
        |=> !first_data_line_oe_o && !second_data_line_oe_o)
        else $error("pin driven in wake-up");
    a_cmd_trigger: assert property (wr_bic && dat_i[BIC_COMMAND_TRIGGER_BIT] &&
        !start && !complete && state_q == ST_IDLE |=> !out_latch_q)
        else $error("command trigger ignored");
    a_clock_parked: assert property (state_q == ST_IDLE &&
        $past(state_q) == ST_IDLE |-> sck_o)
        else $error("clock runs while idle");
endmodule // two_wire_bus

// ### test/far_slave_model.sv
// remote slave on the two-wire bus: takes a byte, returns acknowledge
// assumes sck and the wired data line arrive as levels synchronous to clk
`timescale 1ns/1ps
module far_slave_model (
    input  wire logic       clk_i,
    input  wire logic       ack_en_i,
    input  wire logic       sck_i,
    input  wire logic       line_i,
    output logic            pull_o,
    output logic [7:0]      byte_o
);
    logic       sck_q = 1'b1;
    logic [3:0] cnt_q = 4'h0;
    logic [3:0] idle_q = 4'h0;
    initial pull_o = 1'b0;
    initial byte_o = 8'h00;
    // a long high clock ends the frame, since extra clocks follow the ack
    always @(posedge clk_i) begin
        sck_q <= sck_i;
        idle_q <= sck_i ? idle_q + {3'h0, idle_q != 4'hF} : 4'h0;
        if (idle_q == 4'hC)
            cnt_q <= 4'h0;
        if (sck_i && !sck_q && cnt_q < 4'h8) begin
            byte_o <= {byte_o[6:0], line_i};
            cnt_q <= cnt_q + 4'h1;
        end
        if (!sck_i && sck_q) begin
            if (pull_o) begin
                pull_o <= 1'b0;
                cnt_q <= 4'h9;
            end else if (cnt_q == 4'h8 && ack_en_i)
                pull_o <= 1'b1;
        end
    end
endmodule // far_slave_model

// ### test/tb.sv
// bench: block as bus master on div-8 clock against one remote slave
// assumes pull-ups on the serial clock and data lines
`timescale 1ns/1ps
module tb;
    import two_wire_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, ack_en;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o;
    logic        ack_o, sck_o, sck_oe, d_o, d_oe, pull, line, sck;
    logic [7:0]  got;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // wired-and lines: released means pulled high
    assign line = !(d_oe | pull);
    assign sck  = sck_oe ? sck_o : 1'b1;
    two_wire_bus #(.ACK_TIMEOUT_CYCLES(40)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck), .sck_o(sck_o),
        .sck_oe_o(sck_oe), .timer_output_i(1'b0),
        .first_data_line_i(line), .first_data_line_o(d_o),
        .first_data_line_oe_o(d_oe), .second_data_line_i(1'b1),
        .second_data_line_o(), .second_data_line_oe_o());
    far_slave_model peer (.clk_i(clk_i), .ack_en_i(ack_en), .sck_i(sck),
        .line_i(line), .pull_o(pull), .byte_o(got));
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic check(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, m, e, input string n);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        check(n, e, q & m);
    endtask
    // polls status; a transfer at div 8 takes well under 60 reads
    task automatic wait_st(input int b);
        logic [7:0] q;
        int n;
        n = 0;
        q = 8'h00;
        while (q[b] !== 1'b1 && n < 60) begin
            wb(1'b0, STATUS_OFS, 8'h00, q);
            n++;
        end
        check("wait_flag", 8'h01, {7'h0, q[b]});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(MODE_OFS, 8'hFF, 8'h00, "mode");
        rd(BIC_OFS, 8'hFF, 8'h00, "control");
        rd(SHIFT_OFS, 8'hFF, 8'hFF, "shift");
        rd(8'h40, 8'hFF, 8'h00, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_match();
        rd(MODE_OFS, 8'h40, 8'h00, "match_off");
        wr(OWN_ADDR_OFS, 8'hFF);
        rd(MODE_OFS, 8'h40, 8'h40, "match_on");
        wr(OWN_ADDR_OFS, 8'h5A);
        wr(MODE_OFS, 8'h6B);
        rd(MODE_OFS, 8'hFF, 8'h2B, "mode_rw");
        $display("test match done");
    endtask
    task automatic t_xfer();
        wr(MODE_OFS, 8'h8B);
        wr(SHIFT_OFS, 8'hA5);
        wait_st(ST_IRQ_BIT);
        check("peer_byte", 8'hA5, got);
        // the flag comes at byte end; ack and park follow later
        repeat (32) @(posedge clk_i);
        rd(BIC_OFS, 8'h02, 8'h02, "ack_seen");
        rd(STATUS_OFS, 8'h1B, 8'h01, "status");
        wr(STATUS_OFS, 8'h03);
        $display("test transfer done");
    endtask
    task automatic t_noack();
        ack_en <= 1'b0;
        wr(SHIFT_OFS, 8'h3C);
        wait_st(ST_TOUT_BIT);
        check("peer_byte", 8'h3C, got);
        rd(STATUS_OFS, 8'h03, 8'h03, "status");
        rd(BIC_OFS, 8'h02, 8'h00, "ack_seen");
        wr(STATUS_OFS, 8'h03);
        ack_en <= 1'b1;
        $display("test no ack done");
    endtask
    task automatic t_trig();
        wr(BIC_OFS, 8'h40);
        rd(BIC_OFS, 8'hC0, 8'h00, "trig_clear");
        check("line_cmd", 8'h00, {7'h0, line});
        wr(BIC_OFS, 8'h80);
        rd(BIC_OFS, 8'hC0, 8'h00, "trig_clear");
        check("line_rel", 8'h01, {7'h0, line});
        $display("test triggers done");
    endtask
    // release already seen: command, then own address selects us
    task automatic t_addr();
        wr(BIC_OFS, 8'h45);
        wr(SHIFT_OFS, 8'h5A);
        wait_st(ST_IRQ_BIT);
        check("peer_byte", 8'h5A, got);
        repeat (32) @(posedge clk_i);
        rd(STATUS_OFS, 8'h3F, 8'h35, "addr_busy");
        wr(BIC_OFS, 8'h04);
        repeat (32) @(posedge clk_i);
        rd(STATUS_OFS, 8'h04, 8'h00, "busy_off");
        rd(BIC_OFS, 8'h02, 8'h02, "self_ack");
        wr(STATUS_OFS, 8'h03);
        wr(BIC_OFS, 8'h00);
        $display("test address done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, hang guard and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // the whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, ack_en} = 4'h1;
        adr = 8'h00;
        dat = 32'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_match();
        t_xfer();
        t_noack();
        t_trig();
        t_addr();
        finish_test();
    end
endmodule // tb
